// ### design/tec_defines.svh
// Constants of the timer/event counter block
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH
// ****************************
// Clocking
// ****************************
`define TEC_CLK_NS 25
`define TEC_CP_NS 25
`define TEC_SUB_LAST 2'h2
`define TEC_SLOT_LAST 4'h9
`define TEC_STARTUP_CP 1866
`define TEC_STARTUP_CYC ((`TEC_STARTUP_CP * `TEC_CP_NS + `TEC_CLK_NS - 1) / `TEC_CLK_NS)
`define TEC_TD_NS 1000000
`define TEC_TD_CYC (`TEC_TD_NS / `TEC_CLK_NS)
// ****************************
// Counter and status byte
// ****************************
`define TEC_CNT_MAX 8'hFF
`define TEC_PRE_MAX 5'h1F
`define TEC_PS_BIT 3
`define TEC_UNUSED_BIT 5
`define TEC_INT_EXT 0
`define TEC_INT_SER 1
`define TEC_INT_TMR 2
`endif

// ### design/tec_pkg.sv
// Types of the timer/event counter block
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_STOPPED = 2'b00,
    TEC_TIMER = 2'b01,
    TEC_EVENT = 2'b10
  } tec_mode_t;
endpackage

// ### design/tec_timer.sv
// Timer/event counter with machine cycle, oscillator halt and reset control
// Notes on behaviour
// - Machine cycle is ten slots of three oscillator periods, thirty in all.
// - Eight-bit up counter, loadable and readable by the processor.
// - Timer mode counts prescaler overflows, or machine cycles when bypassed.
// - Event mode counts each rising edge on the event input.
// - At most one event edge per thirty periods; source holds low and high >4.
// - Counter never advances more than once per machine cycle.
// - Overflow sets the overflow flag, which stays until cleared.
// - Jump on flag set or clear tests the flag and clears it.
// - Overflow sets the timer interrupt flag only while timer interrupt enabled.
// - Status bit 3 zero divides by 32, one bypasses the prescaler.
// - Prescale select changes only by status write or reset; status byte is readable.
// - Start timer clears the prescaler; prescaler is never readable.
// - Reading the count does not disturb counting.
// - Reset stops the counter and clears it to zero.
// - Reset selects divide by 32 and clears the overflow flag.
// - Reset disables external, timer and serial interrupts.
// - Reset cancels idle and oscillator halt.
// - After reset, wait 1866 oscillator periods before execution resumes.
// - Halted oscillator restarts on high wake or reset pin if supply good.
// - Oscillator is inhibited while low voltage is present.
// - Detector drives reset pin high at low supply, releases after fixed delay.
// - Event input also serves as branch test for high and for low.
// - Overflow flag cleared only by flag jumps or reset.
`timescale 1ns/1ps
`include "tec_defines.svh"
module tec_timer
  import tec_pkg::*;
#(
  parameter int TD_CYCLES = `TEC_TD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reset_pin_in,
  input wire logic low_voltage_in,
  input wire logic wake_enable_input,
  input wire logic event_count_input,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] cpu_status_in,
  input wire logic load_count_op,
  input wire logic read_count_op,
  input wire logic start_timer_op,
  input wire logic start_event_count_op,
  input wire logic halt_count_op,
  input wire logic write_status_op,
  input wire logic read_status_op,
  input wire logic jump_if_overflow_set,
  input wire logic jump_if_overflow_clear,
  input wire logic branch_on_event_high,
  input wire logic branch_on_event_low,
  input wire logic osc_halt_op,
  input wire logic idle_op,
  input wire logic int_enable_op,
  input wire logic int_disable_op,
  input wire logic [1:0] int_select,
  input wire logic timer_int_ack_op,
  output logic [7:0] read_data_out,
  output logic jump_taken_out,
  output logic timer_int_flag_out,
  output logic [2:0] int_enable_out,
  output logic osc_running_out,
  output logic idle_out,
  output logic cpu_run_out,
  output logic reset_pin_out,
  output logic reset_pin_oe
);
  // ****************************
  // Input synchronisers
  // ****************************
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic evt_prev_ff;
  logic rst_s;
  logic lv_s;
  logic wake_s;
  logic evt_s;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
      evt_prev_ff <= 1'b0;
    end else begin
      meta_ff <= {event_count_input, wake_enable_input, low_voltage_in, reset_pin_in};
      sync_ff <= meta_ff;
      evt_prev_ff <= sync_ff[3];
    end
  end
  assign rst_s = sync_ff[0];
  assign lv_s = sync_ff[1];
  assign wake_s = sync_ff[2];
  assign evt_s = sync_ff[3];

  // ****************************
  // Low-voltage detector and reset pin
  // ****************************
  logic drive_ff;
  logic [31:0] td_cnt_ff;
  logic rst_int;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_ff <= 1'b1;
      td_cnt_ff <= 32'h0;
    end else if (lv_s) begin
      drive_ff <= 1'b1;
      td_cnt_ff <= 32'h0;
    end else if (drive_ff) begin
      if (td_cnt_ff >= TD_CYCLES - 1) begin
        drive_ff <= 1'b0;
      end
      td_cnt_ff <= td_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_pin_out <= 1'b1;
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_out <= drive_ff || lv_s;
      reset_pin_oe <= drive_ff || lv_s;
    end
  end
  assign rst_int = rst_s || drive_ff || lv_s;

  // ****************************
  // Oscillator, idle and start-up delay
  // ****************************
  logic osc_run_ff;
  logic [11:0] start_cnt_ff;
  logic nxt_tif;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_run_ff <= 1'b0;
    end else if (lv_s) begin
      osc_run_ff <= 1'b0;
    end else if (rst_int || wake_s) begin
      osc_run_ff <= 1'b1;
    end else if (osc_halt_op) begin
      osc_run_ff <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_out <= 1'b0;
    end else if (rst_int || nxt_tif) begin
      idle_out <= 1'b0;
    end else if (idle_op) begin
      idle_out <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_cnt_ff <= 12'h0;
      cpu_run_out <= 1'b0;
    end else if (rst_int) begin
      start_cnt_ff <= 12'h0;
      cpu_run_out <= 1'b0;
    end else if (!cpu_run_out && osc_run_ff) begin
      if (start_cnt_ff == 12'(`TEC_STARTUP_CYC - 1)) begin
        cpu_run_out <= 1'b1;
      end
      start_cnt_ff <= start_cnt_ff + 12'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_running_out <= 1'b0;
    end else begin
      osc_running_out <= osc_run_ff;
    end
  end

  // ****************************
  // Machine cycle
  // ****************************
  logic [1:0] sub_ff;
  logic [3:0] slot_ff;
  logic mc_tick;
  assign mc_tick = osc_run_ff && sub_ff == `TEC_SUB_LAST && slot_ff == `TEC_SLOT_LAST;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_ff <= 2'h0;
      slot_ff <= 4'h0;
    end else if (rst_int) begin
      sub_ff <= 2'h0;
      slot_ff <= 4'h0;
    end else if (osc_run_ff) begin
      if (sub_ff == `TEC_SUB_LAST) begin
        sub_ff <= 2'h0;
        slot_ff <= (slot_ff == `TEC_SLOT_LAST) ? 4'h0 : slot_ff + 4'h1;
      end else begin
        sub_ff <= sub_ff + 2'h1;
      end
    end
  end

  // ****************************
  // Mode, prescaler and counter
  // ****************************
  tec_mode_t mode_ff;
  logic ps_ff;
  logic [4:0] pre_ff;
  logic [7:0] count_ff;
  logic evt_pend_ff;
  logic cnt_inc;
  logic cnt_ovf;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= TEC_STOPPED;
    end else if (rst_int || halt_count_op) begin
      mode_ff <= TEC_STOPPED;
    end else if (start_timer_op) begin
      mode_ff <= TEC_TIMER;
    end else if (start_event_count_op) begin
      mode_ff <= TEC_EVENT;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_ff <= 1'b0;
    end else if (rst_int) begin
      ps_ff <= 1'b0;
    end else if (write_status_op) begin
      ps_ff <= acc_in[`TEC_PS_BIT];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 5'h0;
    end else if (rst_int || start_timer_op) begin
      pre_ff <= 5'h0;
    end else if (mc_tick && mode_ff == TEC_TIMER) begin
      pre_ff <= pre_ff + 5'h1;
    end
  end
  // Edge caught any time in event mode, consumed at most once per machine cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_pend_ff <= 1'b0;
    end else if (rst_int || mode_ff != TEC_EVENT) begin
      evt_pend_ff <= 1'b0;
    end else if (evt_s && !evt_prev_ff) begin
      evt_pend_ff <= 1'b1;
    end else if (mc_tick) begin
      evt_pend_ff <= 1'b0;
    end
  end
  always_comb begin
    cnt_inc = 1'b0;
    case (mode_ff)
      TEC_TIMER: cnt_inc = mc_tick && (ps_ff || pre_ff == `TEC_PRE_MAX);
      TEC_EVENT: cnt_inc = mc_tick && evt_pend_ff;
      default: cnt_inc = 1'b0;
    endcase
  end
  assign cnt_ovf = cnt_inc && count_ff == `TEC_CNT_MAX && !load_count_op && !rst_int;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 8'h0;
    end else if (rst_int) begin
      count_ff <= 8'h0;
    end else if (load_count_op) begin
      count_ff <= acc_in;
    end else if (cnt_inc) begin
      count_ff <= count_ff + 8'h1;
    end
  end

  // ****************************
  // Flags and interrupt enables
  // ****************************
  logic tf_ff;
  logic flag_jump;
  assign flag_jump = jump_if_overflow_set || jump_if_overflow_clear;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tf_ff <= 1'b0;
    end else if (rst_int) begin
      tf_ff <= 1'b0;
    end else if (cnt_ovf) begin
      tf_ff <= 1'b1;
    end else if (flag_jump) begin
      tf_ff <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_out <= 3'h0;
    end else if (rst_int) begin
      int_enable_out <= 3'h0;
    end else if (int_enable_op) begin
      int_enable_out[int_select] <= 1'b1;
    end else if (int_disable_op) begin
      int_enable_out[int_select] <= 1'b0;
    end
  end
  assign nxt_tif = cnt_ovf && int_enable_out[`TEC_INT_TMR];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_int_flag_out <= 1'b0;
    end else if (rst_int) begin
      timer_int_flag_out <= 1'b0;
    end else if (nxt_tif) begin
      timer_int_flag_out <= 1'b1;
    end else if (timer_int_ack_op) begin
      timer_int_flag_out <= 1'b0;
    end
  end

  // ****************************
  // Processor reads and branch tests
  // ****************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data_out <= 8'h0;
    end else if (read_count_op) begin
      read_data_out <= count_ff;
    end else if (read_status_op) begin
      read_data_out <= {cpu_status_in[7:6], 1'b1, cpu_status_in[4], ps_ff,
                        cpu_status_in[2:0]};
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      jump_taken_out <= 1'b0;
    end else begin
      jump_taken_out <= (jump_if_overflow_set && tf_ff)
                     || (jump_if_overflow_clear && !tf_ff)
                     || (branch_on_event_high && evt_s)
                     || (branch_on_event_low && !evt_s);
    end
  end

  // ****************************
  // Assertions
  // ****************************
  a_mc_phase: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mc_tick |=> !mc_tick [*8])
    else $error("machine cycle shorter than expected");
  a_inc_rate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cnt_inc |-> mc_tick ##1 !cnt_inc [*8])
    else $error("counter advanced twice within a machine cycle");
  a_wrap_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cnt_ovf |=> tf_ff && count_ff == 8'h00)
    else $error("overflow did not wrap and set flag");
  a_flag_jump: assert property (@(posedge sys_clk) disable iff (!reset_n)
    flag_jump && !cnt_ovf |=> !tf_ff)
    else $error("flag jump did not clear flag");
  a_flag_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tf_ff && !flag_jump && !rst_int |=> tf_ff)
    else $error("overflow flag lost");
  a_tif_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !int_enable_out[2] && !timer_int_flag_out |=> !timer_int_flag_out)
    else $error("timer interrupt flag set while disabled");
  a_reset_state: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rst_int |=> count_ff == 8'h00 && mode_ff == TEC_STOPPED && !tf_ff && !ps_ff
                && int_enable_out == 3'h0)
    else $error("reset state wrong");
  a_pre_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start_timer_op |=> pre_ff == 5'h00)
    else $error("start timer did not clear prescaler");
  a_read_keep: assert property (@(posedge sys_clk) disable iff (!reset_n)
    read_count_op && !load_count_op && !rst_int && !cnt_inc |=>
      read_data_out == $past(count_ff) && count_ff == $past(count_ff))
    else $error("count read disturbed the counter");
  a_startup_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(rst_int) |-> !cpu_run_out [*8])
    else $error("execution resumed too early");
  a_lv_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lv_s |=> reset_pin_out && reset_pin_oe && !osc_run_ff)
    else $error("low voltage not handled");
  c_timer_ovf: cover property (@(posedge sys_clk) disable iff (!reset_n)
    mode_ff == TEC_TIMER && cnt_ovf);
  c_event_inc: cover property (@(posedge sys_clk) disable iff (!reset_n)
    mode_ff == TEC_EVENT && cnt_inc);
  c_osc_wake: cover property (@(posedge sys_clk) disable iff (!reset_n)
    !osc_run_ff && wake_s && !lv_s);
endmodule

// ### sim/tec_event_src.sv
// Model of the external event source on the count input
`timescale 1ns/1ps
module tec_event_src (
  input wire logic sys_clk,
  output logic ev_out
);
  // ****************************
  // Pulse generator
  // ****************************
  initial ev_out = 1'b0;
  // Each level is held thirty periods, so one rising edge per sixty periods
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (30) @(posedge sys_clk);
      #1 ev_out = 1'b1;
      repeat (30) @(posedge sys_clk);
      #1 ev_out = 1'b0;
    end
  endtask
endmodule

// ### sim/test_mcu_timer_event_counter.sv
// Self-checking bench of the timer/event counter
`timescale 1ns/1ps
module test_mcu_timer_event_counter
  import tec_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rpin = 1'b0;
  logic wake = 1'b0;
  logic lv = 1'b0;
  logic [15:0] ops = 16'h0000;
  logic [7:0] acc = 8'h00;
  logic [1:0] isel = 2'h0;
  logic ev;
  logic [7:0] rdata;
  logic jump, tint, orun, idle, run, rp_out, rp_oe;
  logic [2:0] ien;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  always #12.5 sys_clk = ~sys_clk;
  tec_event_src src (.sys_clk(sys_clk), .ev_out(ev));
  tec_timer #(.TD_CYCLES(20)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .reset_pin_in(rpin), .low_voltage_in(lv),
    .wake_enable_input(wake), .event_count_input(ev), .acc_in(acc), .cpu_status_in(8'hC7),
    .load_count_op(ops[0]), .read_count_op(ops[1]), .start_timer_op(ops[2]),
    .start_event_count_op(ops[3]), .halt_count_op(ops[4]), .write_status_op(ops[5]),
    .read_status_op(ops[6]), .jump_if_overflow_set(ops[7]), .jump_if_overflow_clear(ops[8]),
    .branch_on_event_high(ops[9]), .branch_on_event_low(ops[10]), .osc_halt_op(ops[11]),
    .idle_op(ops[12]), .int_enable_op(ops[13]), .int_disable_op(ops[14]),
    .int_select(isel), .timer_int_ack_op(ops[15]), .read_data_out(rdata),
    .jump_taken_out(jump), .timer_int_flag_out(tint), .int_enable_out(ien),
    .osc_running_out(orun), .idle_out(idle), .cpu_run_out(run),
    .reset_pin_out(rp_out), .reset_pin_oe(rp_oe)
  );
  // ****************************
  // Helpers
  // ****************************
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wt(input int n);
    repeat (n) tick;
  endtask
  task automatic pulse(input int i);
    tick;
    ops[i] = 1'b1;
    tick;
    ops[i] = 1'b0;
  endtask
  // Jump ops answer on jump_taken_out, reads on read_data_out
  task automatic rd(input int i, input logic [7:0] exp);
    pulse(i);
    chk(i > 6 ? {15'h0000, jump} : {8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic set(input logic [7:0] a, input int i);
    acc = a;
    pulse(i);
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset_state;
    wt(5);
    chk({rp_out, rp_oe}, 16'h0003);
    for (int k = 0; k < 3000 && run !== 1'b1; k++) tick;
    chk(rp_oe, 16'h0000);
    chk({orun, idle, tint, ien}, 16'h0020);
    rd(1, 8'h00);
    rd(6, 8'hE7);
  endtask
  task automatic t_bypass;
    set(8'h08, 5);
    rd(6, 8'hEF);
    set(8'hFE, 0);
    isel = 2'h2;
    pulse(13);
    pulse(2);
    for (int k = 0; k < 100 && tint !== 1'b1; k++) tick;
    t0 = cyc;
    chk(tint, 16'h0001);
    rd(1, 8'h00);
    wt(40);
    rd(1, 8'h01);
    rd(7, 8'h01);
    rd(7, 8'h00);
    pulse(15);
    for (int k = 0; k < 8000 && tint !== 1'b1; k++) tick;
    chk(16'(cyc - t0), 16'h1E00);
  endtask
  task automatic t_prescale;
    pulse(4);
    set(8'h00, 5);
    pulse(0);
    pulse(2);
    wt(925);
    rd(1, 8'h00);
    wt(75);
    rd(1, 8'h01);
  endtask
  task automatic t_event;
    pulse(4);
    pulse(7);
    pulse(0);
    pulse(14);
    pulse(15);
    pulse(3);
    src.pulses(5);
    wt(40);
    rd(1, 8'h05);
    rd(10, 8'h01);
    rd(9, 8'h00);
    set(8'hFF, 0);
    src.pulses(1);
    wt(40);
    chk(tint, 16'h0000);
    rd(8, 8'h00);
    rd(7, 8'h00);
  endtask
  task automatic t_pin_reset;
    pulse(11);
    wt(3);
    chk(orun, 16'h0000);
    wake = 1'b1;
    wt(6);
    chk(orun, 16'h0001);
    wake = 1'b0;
    for (int s = 0; s < 3; s++) begin
      isel = 2'(s);
      pulse(13);
    end
    chk(ien, 16'h0007);
    set(8'h08, 5);
    pulse(2);
    pulse(12);
    chk(idle, 16'h0001);
    pulse(11);
    wt(3);
    rpin = 1'b1;
    wt(6);
    chk({orun, idle, ien, run}, 16'h0020);
    rpin = 1'b0;
    wt(1860);
    chk(run, 16'h0000);
    wt(15);
    chk(run, 16'h0001);
    rd(1, 8'h00);
    wt(40);
    rd(1, 8'h00);
    rd(6, 8'hE7);
  endtask
  task automatic t_low_volt;
    lv = 1'b1;
    wt(5);
    chk({rp_out, rp_oe, orun, run}, 16'h000C);
    lv = 1'b0;
    wt(12);
    chk({rp_out, rp_oe}, 16'h0003);
    wt(20);
    chk({rp_out, rp_oe, orun}, 16'h0001);
  endtask
  // ****************************
  // Sequence and timeout
  // ****************************
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    t_reset_state;
    t_bypass;
    t_prescale;
    t_event;
    t_pin_reset;
    t_low_volt;
    print_verdict;
  end
endmodule
